// ### rtl/evsb_top.v
// Event status register, its enable mask and the operation status
// hierarchy, reached through a remote command port.
// Assumes a command parser on the same clock presents decoded commands
// and raises one-cycle error pulses; the local key arrives from a pin.
//
// Summary of operation
// - Event status register clears on read.
// - Enabled rising event bit sets summary.
// - Bit 0 after prior commands finish.
// - Bit 1 on controller role request.
// - Bit 2 on query protocol error.
// - Bit 3 on device-dependent error.
// - Bit 4 on execution error.
// - Bit 5 on command error.
// - Bit 6 on switch to local control.
// - Bit 7 set once at power-up.
// - Enable mask is writable and readable.
// - Each operation register has five parts.
// - Task summary bits per network standard.
// - Function group bits per application.
// - Application state bits zero to four; generator bits zero to two.
// - Application registers record state transitions.
// - Top register summarises all tasks.
// - Wait commands for condition or event.
// - Rising filter gates event setting.
// - Event summary is status byte bit 5.
`timescale 1ns/1ps
`default_nettype none
`include "evsb_consts.vh"

module evsb_top (
  input wire clock_i,              // Clock, 25 MHz.
  input wire reset_n_i,            // Asynchronous reset, active low.
  input wire cmd_valid_i,          // Command present.
  input wire [2:0] cmd_op_i,       // Command operation.
  input wire [3:0] cmd_reg_i,      // Register selector.
  input wire [2:0] cmd_part_i,     // Register part.
  input wire [15:0] cmd_data_i,    // Write data or wait mask.
  output wire cmd_ready_o,         // Command accepted when high.
  output reg rsp_valid_o,          // Response pulse.
  output reg [15:0] rsp_data_o,    // Response data.
  input wire busy_i,               // Earlier commands still running.
  input wire ctrl_req_i,           // Controller role request pulse.
  input wire query_err_i,          // Query error pulse.
  input wire dev_err_i,            // Device-dependent error pulse.
  input wire exec_err_i,           // Execution error pulse.
  input wire cmd_err_i,            // Command error pulse.
  input wire local_key_i,          // Local key pin, asynchronous.
  input wire [44:0] app_state_i,   // Application states, 5 bits each.
  input wire [9:0] std_sum_i,      // Other standards, data last.
  output wire event_summary_bit_o, // Status byte bit 5.
  output wire op_summary_o         // Operation summary.
);

  // ============================================================
  // State machine
  localparam ST_IDLE = 2'b00;
  localparam ST_DONE = 2'b01;
  localparam ST_WCOND = 2'b10;
  localparam ST_WEVT = 2'b11;

  localparam NS = `EVSB_NUM_SCPI;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] wreg_r;
  reg [15:0] wmask_r;
  reg [7:0] evst_r;
  reg [7:0] evst_nxt;
  reg [7:0] evmsk_r;
  reg key_d_r;
  reg [15:0] rd_mux;
  reg [16*NS-1:0] cond_in;
  reg [NS-1:0] wr_rise;
  reg [NS-1:0] wr_fall;
  reg [NS-1:0] wr_ena;
  reg [NS-1:0] evt_clr;
  reg [7:0] evst_set;
  integer k;
  integer m;

  wire key_w;
  wire take_w;
  wire [16*NS-1:0] cond_f;
  wire [16*NS-1:0] rise_f;
  wire [16*NS-1:0] fall_f;
  wire [16*NS-1:0] evt_f;
  wire [16*NS-1:0] ena_f;
  wire [NS-1:0] sum_w;
  wire [15:0] wcond_w;
  wire [15:0] wevt_w;
  wire done_set_w;

  function [15:0] pick;
    input [16*NS-1:0] bus;
    input [3:0] idx;
    begin
      pick = bus[idx*16 +: 16];
    end
  endfunction

  // ============================================================
  // Pin input and command decode
  evsb_sync u_key_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(local_key_i),
    .level_o(key_w)
  );

  assign cmd_ready_o = (state_r == ST_IDLE);
  assign take_w = cmd_valid_i & cmd_ready_o;
  assign wcond_w = pick(cond_f, wreg_r) & wmask_r;
  assign wevt_w = pick(evt_f, wreg_r) & wmask_r;

  assign done_set_w = ((state_r == ST_DONE) & !busy_i) |
                      (take_w & (cmd_op_i == `EVSB_OP_DONE) & !busy_i);

  assign event_summary_bit_o = |(evst_r & evmsk_r);
  assign op_summary_o = sum_w[`EVSB_REG_TOP];

  // ============================================================
  // Hierarchy wiring
  always @*
  begin
    cond_in = {16*NS{1'b0}};
    for (k = 0; k < `EVSB_NUM_APP; k = k + 1)
    begin
      if (k == `EVSB_GEN_BASE)
        cond_in[(`EVSB_REG_APP0 + k)*16 +: `EVSB_APP_W] =
          app_state_i[k*`EVSB_APP_W +: `EVSB_APP_W] & `EVSB_GEN_MASK;
      else
        cond_in[(`EVSB_REG_APP0 + k)*16 +: `EVSB_APP_W] =
          app_state_i[k*`EVSB_APP_W +: `EVSB_APP_W] & `EVSB_STATE_MASK;
    end
    for (k = 0; k < `EVSB_MEAS_APPS; k = k + 1)
      cond_in[`EVSB_REG_FG_MEAS*16 + k] =
        sum_w[`EVSB_REG_APP0 + `EVSB_MEAS_BASE + k];
    for (k = 0; k < `EVSB_SIG_APPS; k = k + 1)
      cond_in[`EVSB_REG_FG_SIG*16 + k] =
        sum_w[`EVSB_REG_APP0 + `EVSB_SIG_BASE + k];
    cond_in[`EVSB_REG_FG_GEN*16] = sum_w[`EVSB_REG_APP0 + `EVSB_GEN_BASE];
    cond_in[`EVSB_REG_TASK*16 + `EVSB_TASK_GENRF_BIT] =
      |sum_w[`EVSB_REG_FG_GEN:`EVSB_REG_FG_MEAS];
    for (k = 0; k < `EVSB_TASK_STD_NUM; k = k + 1)
      cond_in[`EVSB_REG_TASK*16 + `EVSB_TASK_STD_BIT + k] = std_sum_i[k];
    cond_in[`EVSB_REG_TASK*16 + `EVSB_TASK_DATA_BIT] =
      std_sum_i[`EVSB_TASK_STD_NUM];
    cond_in[`EVSB_REG_TOP*16 + `EVSB_TOP_TASK_BIT] = sum_w[`EVSB_REG_TASK];
  end

  // ============================================================
  // Write and clear strobes
  always @*
  begin
    for (m = 0; m < NS; m = m + 1)
    begin
      wr_rise[m] = take_w & (cmd_op_i == `EVSB_OP_WRITE) &
                   (cmd_reg_i == m[3:0]) & (cmd_part_i == `EVSB_PART_RISE);
      wr_fall[m] = take_w & (cmd_op_i == `EVSB_OP_WRITE) &
                   (cmd_reg_i == m[3:0]) & (cmd_part_i == `EVSB_PART_FALL);
      wr_ena[m] = take_w & (cmd_op_i == `EVSB_OP_WRITE) &
                  (cmd_reg_i == m[3:0]) & (cmd_part_i == `EVSB_PART_ENA);
      evt_clr[m] = (take_w & (cmd_op_i == `EVSB_OP_READ) &
                    (cmd_reg_i == m[3:0]) &
                    (cmd_part_i == `EVSB_PART_EVT)) |
                   ((state_r == ST_WEVT) & (wevt_w != 16'h0000) &
                    (wreg_r == m[3:0]));
    end
  end

  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1)
    begin : g_reg
      evsb_scpi_reg u_reg (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .cond_i(cond_in[g*16 +: 16]),
        .wdata_i(cmd_data_i),
        .wr_rise_i(wr_rise[g]),
        .wr_fall_i(wr_fall[g]),
        .wr_ena_i(wr_ena[g]),
        .evt_clr_i(evt_clr[g]),
        .cond_o(cond_f[g*16 +: 16]),
        .rise_o(rise_f[g*16 +: 16]),
        .fall_o(fall_f[g*16 +: 16]),
        .evt_o(evt_f[g*16 +: 16]),
        .ena_o(ena_f[g*16 +: 16]),
        .sum_o(sum_w[g])
      );
    end
  endgenerate

  // ============================================================
  // Event status register
  always @*
  begin
    evst_set = 8'h00;
    evst_set[`EVSB_EV_DONE] = done_set_w;
    evst_set[`EVSB_EV_RQC] = ctrl_req_i;
    evst_set[`EVSB_EV_QYE] = query_err_i;
    evst_set[`EVSB_EV_DDE] = dev_err_i;
    evst_set[`EVSB_EV_EXE] = exec_err_i;
    evst_set[`EVSB_EV_CME] = cmd_err_i;
    evst_set[`EVSB_EV_URQ] = key_w & !key_d_r;
    evst_nxt = evst_r;
    if (take_w & (cmd_op_i == `EVSB_OP_READ) & (cmd_reg_i == `EVSB_REG_EVST))
      evst_nxt = 8'h00;
    // A new event in the read cycle is kept for the next read.
    evst_nxt = evst_nxt | evst_set;
  end

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      evst_r <= `EVSB_EV_RESET;
      evmsk_r <= `EVSB_EVMSK_RESET;
      key_d_r <= 1'b0;
    end
    else
    begin
      evst_r <= evst_nxt;
      key_d_r <= key_w;
      if (take_w & (cmd_op_i == `EVSB_OP_WRITE) &
          (cmd_reg_i == `EVSB_REG_EVMSK))
        evmsk_r <= cmd_data_i[7:0];
    end
  end

  // ============================================================
  // Read multiplexer
  always @*
  begin
    rd_mux = 16'h0000;
    if (cmd_reg_i == `EVSB_REG_EVST)
      rd_mux = {8'h00, evst_r};
    else if (cmd_reg_i == `EVSB_REG_EVMSK)
      rd_mux = {8'h00, evmsk_r};
    else
    begin
      case (cmd_part_i)
        `EVSB_PART_COND: rd_mux = pick(cond_f, cmd_reg_i);
        `EVSB_PART_RISE: rd_mux = pick(rise_f, cmd_reg_i);
        `EVSB_PART_FALL: rd_mux = pick(fall_f, cmd_reg_i);
        `EVSB_PART_EVT: rd_mux = pick(evt_f, cmd_reg_i);
        `EVSB_PART_ENA: rd_mux = pick(ena_f, cmd_reg_i);
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  // ============================================================
  // Command sequencing
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (take_w & (cmd_op_i == `EVSB_OP_DONE) & busy_i)
          state_nxt = ST_DONE;
        else if (take_w & (cmd_op_i == `EVSB_OP_WCOND))
          state_nxt = ST_WCOND;
        else if (take_w & (cmd_op_i == `EVSB_OP_WEVENT))
          state_nxt = ST_WEVT;
      end
      ST_DONE:
      begin
        if (!busy_i)
          state_nxt = ST_IDLE;
      end
      ST_WCOND:
      begin
        if (wcond_w != 16'h0000)
          state_nxt = ST_IDLE;
      end
      ST_WEVT:
      begin
        if (wevt_w != 16'h0000)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Waits look at whichever register the command selects, top and task included;
  // nothing keeps the wait selector off the event status register.
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= ST_IDLE;
      wreg_r <= 4'h0;
      wmask_r <= 16'h0000;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      rsp_valid_o <= 1'b0;
      if (take_w)
      begin
        wreg_r <= cmd_reg_i;
        wmask_r <= cmd_data_i;
      end
      if (take_w & (cmd_op_i == `EVSB_OP_READ))
      begin
        rsp_valid_o <= 1'b1;
        rsp_data_o <= rd_mux;
      end
      else if ((state_r == ST_WCOND) & (wcond_w != 16'h0000))
      begin
        rsp_valid_o <= 1'b1;
        rsp_data_o <= wcond_w;
      end
      else if ((state_r == ST_WEVT) & (wevt_w != 16'h0000))
      begin
        rsp_valid_o <= 1'b1;
        rsp_data_o <= wevt_w;
      end
    end
  end

endmodule

`default_nettype wire

// ### shared/evsb_consts.vh
// Constants for the event and operation status bank.
// Assumes inclusion by bare name from each design file of the bank that uses its constants.
`ifndef EVSB_CONSTS_VH
`define EVSB_CONSTS_VH

// ============================================================
// Remote command operations
`define EVSB_OP_READ 3'h0
`define EVSB_OP_WRITE 3'h1
`define EVSB_OP_WCOND 3'h2
`define EVSB_OP_WEVENT 3'h3
`define EVSB_OP_DONE 3'h4

// ============================================================
// Register parts
`define EVSB_PART_COND 3'h0
`define EVSB_PART_RISE 3'h1
`define EVSB_PART_FALL 3'h2
`define EVSB_PART_EVT 3'h3
`define EVSB_PART_ENA 3'h4

// ============================================================
// Register selectors
`define EVSB_NUM_SCPI 14
`define EVSB_REG_TOP 4'h0
`define EVSB_REG_TASK 4'h1
`define EVSB_REG_FG_MEAS 4'h2
`define EVSB_REG_FG_SIG 4'h3
`define EVSB_REG_FG_GEN 4'h4
`define EVSB_REG_APP0 4'h5
`define EVSB_REG_EVST 4'he
`define EVSB_REG_EVMSK 4'hf

// ============================================================
// Hierarchy layout
`define EVSB_NUM_APP 9
`define EVSB_MEAS_APPS 5
`define EVSB_SIG_APPS 3
`define EVSB_MEAS_BASE 0
`define EVSB_SIG_BASE 5
`define EVSB_GEN_BASE 8
`define EVSB_APP_W 5
`define EVSB_STATE_MASK 5'h1f
`define EVSB_GEN_MASK 5'h07
`define EVSB_TOP_TASK_BIT 0
`define EVSB_TASK_GENRF_BIT 1
`define EVSB_TASK_STD_BIT 2
`define EVSB_TASK_STD_NUM 9
`define EVSB_TASK_DATA_BIT 12

// ============================================================
// Event status register bits and reset values
`define EVSB_EV_DONE 0
`define EVSB_EV_RQC 1
`define EVSB_EV_QYE 2
`define EVSB_EV_DDE 3
`define EVSB_EV_EXE 4
`define EVSB_EV_CME 5
`define EVSB_EV_URQ 6
`define EVSB_EV_PON 7
`define EVSB_EV_RESET 8'h80
`define EVSB_EVMSK_RESET 8'h00
`define EVSB_RISE_RESET 16'hffff
`define EVSB_FALL_RESET 16'h0000
`define EVSB_ENA_RESET 16'h0000

`endif

// ### rtl/evsb_sync.v
// Three-stage synchroniser for one asynchronous level input.
// Assumes a single clock; output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module evsb_sync (
  input wire clock_i,   // Clock.
  input wire reset_n_i, // Asynchronous reset, active low.
  input wire async_i,   // Level from outside the clock domain.
  output reg level_o    // Filtered, synchronised level.
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level_o <= s3_r;
    end
  end

endmodule

`default_nettype wire

// ### rtl/evsb_scpi_reg.v
// One five-part status register: condition, two transition filters,
// event and enable. Assumes the parent decodes writes and reads.
`timescale 1ns/1ps
`default_nettype none
`include "evsb_consts.vh"

module evsb_scpi_reg (
  input wire clock_i,          // Clock.
  input wire reset_n_i,        // Asynchronous reset, active low.
  input wire [15:0] cond_i,    // Live condition bits.
  input wire [15:0] wdata_i,   // Write data.
  input wire wr_rise_i,        // Write rising filter.
  input wire wr_fall_i,        // Write falling filter.
  input wire wr_ena_i,         // Write enable mask.
  input wire evt_clr_i,        // Event part read, clear it.
  output reg [15:0] cond_o,    // Registered condition.
  output reg [15:0] rise_o,    // Rising transition filter.
  output reg [15:0] fall_o,    // Falling transition filter.
  output reg [15:0] evt_o,     // Event part.
  output reg [15:0] ena_o,     // Enable part.
  output wire sum_o            // Summary to parent.
);

  wire [15:0] set_w;
  wire [15:0] evt_nxt;

  assign set_w = (cond_i & ~cond_o & rise_o) | (~cond_i & cond_o & fall_o);
  assign evt_nxt = (evt_o & ~{16{evt_clr_i}}) | set_w;
  assign sum_o = |(evt_o & ena_o);

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cond_o <= 16'h0000;
      rise_o <= `EVSB_RISE_RESET;
      fall_o <= `EVSB_FALL_RESET;
      evt_o <= 16'h0000;
      ena_o <= `EVSB_ENA_RESET;
    end
    else
    begin
      cond_o <= cond_i;
      evt_o <= evt_nxt;
      if (wr_rise_i)
        rise_o <= wdata_i;
      if (wr_fall_i)
        fall_o <= wdata_i;
      if (wr_ena_i)
        ena_o <= wdata_i;
    end
  end

endmodule

`default_nettype wire

// ### verification/evsb_host.sv
// Remote controller model that issues commands to the status bank.
// Assumes a command port taken on a rising edge with valid and ready.
`timescale 1ns/1ps
`default_nettype none
`include "evsb_consts.vh"

module evsb_host (
  input wire logic clock_i,        // Clock.
  output logic cmd_valid_o,        // Command present.
  output logic [2:0] cmd_op_o,     // Operation.
  output logic [3:0] cmd_reg_o,    // Register selector.
  output logic [2:0] cmd_part_o,   // Register part.
  output logic [15:0] cmd_data_o,  // Write data or wait mask.
  input wire logic cmd_ready_i,    // Command taken when high.
  input wire logic rsp_valid_i,    // Response pulse.
  input wire logic [15:0] rsp_data_i // Response data.
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_op_o = 3'h0;
    cmd_reg_o = 4'h0;
    cmd_part_o = 3'h0;
    cmd_data_o = 16'h0000;
  end

  // ============================================================
  // Command transfer
  // waits hold the port
  task automatic xfer(input logic [2:0] op, input logic [3:0] rg,
                      input logic [2:0] pt, input logic [15:0] d,
                      output logic [15:0] q);
    begin
      q = 16'h0000;
      @(posedge clock_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_op_o = op;
      cmd_reg_o = rg;
      cmd_part_o = pt;
      cmd_data_o = d;
      while (!cmd_ready_i)
        @(posedge clock_i) #1;
      @(posedge clock_i);
      #1;
      cmd_valid_o = 1'b0;
      // Released data and register lines show a changed pattern so stale data cannot pass.
      cmd_data_o = ~d;
      cmd_reg_o = ~rg;
      if (op == `EVSB_OP_READ || op == `EVSB_OP_WCOND ||
          op == `EVSB_OP_WEVENT)
      begin
        // A wait that never answers is ended by the bench's cycle ceiling.
        while (!rsp_valid_i)
        begin
          @(posedge clock_i);
          #1;
        end
        q = rsp_data_i;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### verification/evsb_checker.sv
// Assertions on the status bank ports.
// Assumes a bind to evsb_top; masks are shadowed from observed writes.
`timescale 1ns/1ps
`default_nettype none
`include "evsb_consts.vh"

module evsb_checker (
  input wire logic clock_i,             // Clock.
  input wire logic reset_n_i,           // Reset, active low.
  input wire logic cmd_valid_i,         // Command present.
  input wire logic [2:0] cmd_op_i,      // Operation.
  input wire logic [3:0] cmd_reg_i,     // Register selector.
  input wire logic [2:0] cmd_part_i,    // Register part.
  input wire logic [15:0] cmd_data_i,   // Write data.
  input wire logic cmd_ready_o,         // Ready.
  input wire logic rsp_valid_o,         // Response pulse.
  input wire logic [15:0] rsp_data_o,   // Response data.
  input wire logic busy_i,              // Earlier commands running.
  input wire logic ctrl_req_i,          // Controller role request pulse.
  input wire logic query_err_i,         // Error pulse.
  input wire logic dev_err_i,           // Error pulse.
  input wire logic exec_err_i,          // Error pulse.
  input wire logic cmd_err_i,           // Error pulse.
  input wire logic local_key_i,         // Local key pin.
  input wire logic event_summary_bit_o, // Status byte bit 5.
  input wire logic op_summary_o         // Operation summary.
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] mask_r;
  logic [15:0] top_ena_r;
  wire take = cmd_valid_i & cmd_ready_o;
  wire [4:0] errs = {cmd_err_i, exec_err_i, dev_err_i, query_err_i,
                     ctrl_req_i};
  wire wr = take && cmd_op_i == `EVSB_OP_WRITE;
  wire rd = take && cmd_op_i == `EVSB_OP_READ;
  wire done = take && cmd_op_i == `EVSB_OP_DONE;
  wire wt = take && (cmd_op_i == `EVSB_OP_WCOND ||
                     cmd_op_i == `EVSB_OP_WEVENT);

  // ============================================================
  // Shadow masks
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mask_r <= 8'h00;
      top_ena_r <= 16'h0000;
    end
    else
    begin
      if (wr && cmd_reg_i == `EVSB_REG_EVMSK)
        mask_r <= cmd_data_i[7:0];
      if (wr && cmd_reg_i == `EVSB_REG_TOP && cmd_part_i == `EVSB_PART_ENA)
        top_ena_r <= cmd_data_i;
    end
  end

  // ============================================================
  // Properties
  a_read_answer: assert property (
    rd |=> rsp_valid_o) else $error("read gave no response");
  a_mask_read: assert property (
    rd && cmd_reg_i == `EVSB_REG_EVMSK |=>
    rsp_data_o == {8'h00, $past(mask_r)}) else $error("mask readback");
  a_read_clears: assert property (
    !local_key_i [*5] ##0 (rd && cmd_reg_i == `EVSB_REG_EVST &&
    errs == 5'h00 && !$past(done)) |=> !event_summary_bit_o)
    else $error("status not cleared by read");
  a_err_summary: assert property (
    (errs & mask_r[5:1]) != 5'h00 && !wr |=> event_summary_bit_o)
    else $error("enabled event gave no summary");
  a_no_mask: assert property (
    mask_r == 8'h00 |-> !event_summary_bit_o)
    else $error("summary without enable");
  a_done_set: assert property (
    done && !busy_i && mask_r[0] && !wr |=> event_summary_bit_o)
    else $error("completion bit missing");
  a_done_stall: assert property (
    done && busy_i |=> !cmd_ready_o) else $error("completion not held");
  a_wait_stall: assert property (
    wt |=> !cmd_ready_o && !rsp_valid_o) else $error("wait not held");
  a_no_top_ena: assert property (
    top_ena_r == 16'h0000 |-> !op_summary_o)
    else $error("operation summary without enable");

  c_done: cover property (done && busy_i);
  c_wait: cover property (!cmd_ready_o ##1 rsp_valid_o);
  c_op_sum: cover property ($rose(op_summary_o));
endmodule

bind evsb_top evsb_checker chk_u (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
  .cmd_op_i(cmd_op_i), .cmd_reg_i(cmd_reg_i), .cmd_part_i(cmd_part_i),
  .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
  .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .busy_i(busy_i),
  .ctrl_req_i(ctrl_req_i), .query_err_i(query_err_i),
  .dev_err_i(dev_err_i), .exec_err_i(exec_err_i), .cmd_err_i(cmd_err_i),
  .local_key_i(local_key_i), .event_summary_bit_o(event_summary_bit_o),
  .op_summary_o(op_summary_o));
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the event and operation status bank.
// Assumes the host model drives the command port; pulses come from here.
`timescale 1ns/1ps
`default_nettype none
`include "evsb_consts.vh"

module tb;
  logic clock_i, reset_n_i, busy_i, local_key_i;
  logic [4:0] errs;
  logic [44:0] app_state;
  logic [9:0] std_sum;
  logic [15:0] q;
  wire cmd_valid, cmd_ready, rsp_valid, sum_bit, ops;
  wire [2:0] op, part;
  wire [3:0] rg;
  wire [15:0] data, rsp;
  int errors, check_count, cyc;

  evsb_top dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .cmd_valid_i(cmd_valid), .cmd_op_i(op), .cmd_reg_i(rg),
    .cmd_part_i(part), .cmd_data_i(data), .cmd_ready_o(cmd_ready),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp), .busy_i(busy_i),
    .ctrl_req_i(errs[0]), .query_err_i(errs[1]), .dev_err_i(errs[2]),
    .exec_err_i(errs[3]), .cmd_err_i(errs[4]), .local_key_i(local_key_i),
    .app_state_i(app_state), .std_sum_i(std_sum),
    .event_summary_bit_o(sum_bit), .op_summary_o(ops));
  evsb_host host_u (.clock_i(clock_i), .cmd_valid_o(cmd_valid),
    .cmd_op_o(op), .cmd_reg_o(rg), .cmd_part_o(part), .cmd_data_o(data),
    .cmd_ready_i(cmd_ready), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp));

  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // ============================================================
  // Tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      check_count++;
      if (got !== exp)
      begin
        errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rd(input logic [3:0] r, input logic [2:0] p, input logic [15:0] e);
    begin
      host_u.xfer(`EVSB_OP_READ, r, p, 16'h0000, q);
      chk(q, e);
    end
  endtask
  task wr(input logic [3:0] r, input logic [2:0] p, input logic [15:0] d);
    host_u.xfer(`EVSB_OP_WRITE, r, p, d, q);
  endtask
  task step(input int n);
    begin
      repeat (n) @(posedge clock_i);
      #1;
    end
  endtask
  task end_of_test;
    begin
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Cuts a hang short; the whole sequence needs well under a thousand.
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      end_of_test;
    end
  end

  // ============================================================
  // Sequence
  initial
  begin
    reset_n_i = 1'b0;
    busy_i = 1'b0;
    local_key_i = 1'b0;
    errs = 5'h00;
    app_state = 45'h0;
    std_sum = 10'h000;
    step(12);
    reset_n_i = 1'b1;
    rd(`EVSB_REG_EVST, `EVSB_PART_EVT, 16'h0080);
    rd(`EVSB_REG_EVST, `EVSB_PART_EVT, 16'h0000);
    for (int p = 0; p < 5; p++)
      rd(4'h5, p[2:0], (p == 1) ? 16'hffff : 16'h0000);
    wr(`EVSB_REG_EVMSK, `EVSB_PART_ENA, 16'h12a5);
    rd(`EVSB_REG_EVMSK, `EVSB_PART_ENA, 16'h00a5);
    wr(`EVSB_REG_EVMSK, `EVSB_PART_ENA, 16'h00ff);
    for (int i = 0; i < 5; i++)
    begin
      errs = 5'h01 << i;
      step(1);
      errs = 5'h00;
      step(1);
      chk({15'h0, sum_bit}, 16'h0001);
      rd(`EVSB_REG_EVST, `EVSB_PART_EVT, 16'h0002 << i);
      chk({15'h0, sum_bit}, 16'h0000);
    end
    local_key_i = 1'b1;
    step(8);
    rd(`EVSB_REG_EVST, `EVSB_PART_EVT, 16'h0040);
    local_key_i = 1'b0;
    busy_i = 1'b1;
    fork
      host_u.xfer(`EVSB_OP_DONE, 4'h0, 3'h0, 16'h0000, q);
      begin
        step(6);
        chk({15'h0, sum_bit}, 16'h0000);
        busy_i = 1'b0;
      end
    join
    rd(`EVSB_REG_EVST, `EVSB_PART_EVT, 16'h0001);
    host_u.xfer(`EVSB_OP_DONE, 4'h0, 3'h0, 16'h0000, q);
    rd(`EVSB_REG_EVST, `EVSB_PART_EVT, 16'h0001);
    for (int r = 0; r < 3; r++)
      wr(r[3:0], `EVSB_PART_ENA, 16'hffff);
    wr(4'h6, `EVSB_PART_ENA, 16'hffff);
    chk({15'h0, ops}, 16'h0000);
    app_state[3] = 1'b1;
    app_state[9] = 1'b1;
    app_state[44:40] = 5'h1f;
    std_sum = 10'h201;
    step(12);
    chk({15'h0, ops}, 16'h0001);
    rd(4'h5, `EVSB_PART_EVT, 16'h0008);
    rd(4'h5, `EVSB_PART_EVT, 16'h0000);
    rd(`EVSB_REG_FG_MEAS, `EVSB_PART_COND, 16'h0002);
    rd(`EVSB_REG_TASK, `EVSB_PART_COND, 16'h1006);
    rd(`EVSB_REG_TOP, `EVSB_PART_COND, 16'h0001);
    rd(4'hd, `EVSB_PART_COND, 16'h0007);
    wr(4'h5, `EVSB_PART_RISE, 16'h0000);
    app_state[2] = 1'b1;
    step(4);
    rd(4'h5, `EVSB_PART_EVT, 16'h0000);
    rd(4'h5, `EVSB_PART_COND, 16'h000c);
    wr(4'h5, `EVSB_PART_FALL, 16'h0008);
    app_state[3] = 1'b0;
    step(4);
    rd(4'h5, `EVSB_PART_EVT, 16'h0008);
    fork
      host_u.xfer(`EVSB_OP_WCOND, 4'h5, `EVSB_PART_COND, 16'h0010, q);
      begin
        step(5);
        app_state[4] = 1'b1;
      end
    join
    chk(q, 16'h0010);
    fork
      host_u.xfer(`EVSB_OP_WEVENT, 4'h6, `EVSB_PART_EVT, 16'h0001, q);
      begin
        step(5);
        app_state[5] = 1'b1;
      end
    join
    chk(q, 16'h0001);
    end_of_test;
  end
endmodule
`default_nettype wire
